// ==== rtl/tdc_cfg_pkg.sv ====
// Constants and carrier types for the converter configuration register bank.
// Assumes one system clock and a plain strobe-based register port.
package tdc_cfg_pkg;

	localparam int          NUM_WORDS  = 7;
	localparam int          ADDR_W     = 3;
	localparam int          WORD_W     = 32;
	localparam int          TAG_W      = 8;

	// Word indices, which are also the register port addresses.
	localparam logic [2:0]  ADDR_CFG0  = 3'h0;
	localparam logic [2:0]  ADDR_CFG1  = 3'h1;
	localparam logic [2:0]  ADDR_CFG2  = 3'h2;
	localparam logic [2:0]  ADDR_CFG3  = 3'h3;
	localparam logic [2:0]  ADDR_CFG4  = 3'h4;
	localparam logic [2:0]  ADDR_ECHO  = 3'h5;
	localparam logic [2:0]  ADDR_CFG6  = 3'h6;
	localparam logic [2:0]  ADDR_LAST  = 3'h6;

	// Field positions shared by every word.
	localparam int          TAG_LSB    = 0;
	localparam int          TAG_MSB    = 7;
	localparam int          SET_LSB    = 8;
	localparam int          SET_MSB    = 31;
	localparam int          ECHO_LSB   = 24;

	// Power-up defaults of each word, given as whole 32-bit values.
	localparam logic [31:0] RST_CFG0   = 32'h22066800;
	localparam logic [31:0] RST_CFG1   = 32'h55000000;
	localparam logic [31:0] RST_CFG2   = 32'h20000000;
	localparam logic [31:0] RST_CFG3   = 32'h18000000;
	localparam logic [31:0] RST_CFG4   = 32'h00000000;
	localparam logic [31:0] RST_CFG5   = 32'h00000000;
	localparam logic [31:0] RST_CFG6   = 32'h00000000;
	localparam logic [31:0] RD_IDLE    = 32'h00000000;

	typedef logic [31:0] cfg_word_t;

	typedef cfg_word_t [NUM_WORDS-1:0] cfg_set_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [2:0]  addr;
		logic [31:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic        valid;
		logic [31:0] data;
	} reg_rsp_t;

	localparam cfg_set_t    RST_SET    = {RST_CFG6, RST_CFG5, RST_CFG4, RST_CFG3,
		RST_CFG2, RST_CFG1, RST_CFG0};

endpackage : tdc_cfg_pkg

// ==== rtl/cfg_word_reg.sv ====
// One configuration word: a full 32-bit store loaded on a write strobe.
// Assumes the parent decodes the address and supplies a one-cycle write enable.
`timescale 1ns/1ps
module cfg_word_reg import tdc_cfg_pkg::*; #(
	parameter cfg_word_t RESET_VAL = 32'h00000000
) (
	input  wire logic      clk_sys,   // System clock.
	input  wire logic      sys_rst,   // Synchronous reset, active high.
	input  wire logic      we,        // Write enable for this word.
	input  wire cfg_word_t wdata,     // Data to store.
	output cfg_word_t      word_q     // Stored word.
);

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			word_q <= RESET_VAL;
		end else if (we) begin
			word_q <= wdata;
		end
	end

endmodule : cfg_word_reg

// ==== rtl/tdc_config_register_bank.sv ====
// Configuration register bank of a two-channel time-to-digital converter.
// Assumes a host that drives one-cycle read and write strobes synchronous to clk_sys.
//
// Local design decision: strobed register access.
`timescale 1ns/1ps

module tdc_config_register_bank import tdc_cfg_pkg::*; (
	input  wire logic     clk_sys,   // System clock, 50 MHz.
	input  wire logic     sys_rst,   // Synchronous reset, active high.
	input  wire reg_req_t req,       // Register port request: strobes, address, data.
	output reg_rsp_t      rsp_q,     // Read answer, valid in the cycle after a read.
	output cfg_set_t      cfg_q      // All seven words to the converter logic.
);

	cfg_set_t              word_w;
	logic [NUM_WORDS-1:0]  we_w;
	logic [31:0]           rd_d;

	// Seven identical word stores, each with its own default.
	genvar g;
	generate
		for (g = 0; g < NUM_WORDS; g++) begin : g_word
			assign we_w[g] = req.wr && (req.addr == 3'(g));
			cfg_word_reg #(
				.RESET_VAL (RST_SET[g])
			) u_word (
				.clk_sys   (clk_sys),
				.sys_rst   (sys_rst),
				.we        (we_w[g]),
				.wdata     (req.wdata),
				.word_q    (word_w[g])
			);
		end
	endgenerate

	// Read mux: settings leave through the port only at address 5; at the other addresses up to 6 only the tag byte does, address 7 reads zero.
	// Address 5 also carries the top byte of word 1 as a link check; word 6 and
	// the tag byte of word 1 hold the extended features, the rest keeps the
	// older layout unchanged.
	always_comb begin
		rd_d = RD_IDLE;
		if (req.addr == ADDR_ECHO) begin
			rd_d[TAG_MSB:TAG_LSB]  = word_w[ADDR_ECHO][TAG_MSB:TAG_LSB];
			rd_d[SET_MSB:ECHO_LSB] = word_w[ADDR_CFG1][SET_MSB:ECHO_LSB];
		end else if (req.addr <= ADDR_LAST) begin
			rd_d[TAG_MSB:TAG_LSB]  = word_w[req.addr][TAG_MSB:TAG_LSB];
		end
	end

	// The answer stands for exactly one cycle after the read strobe.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			rsp_q <= '0;
		end else begin
			rsp_q.valid <= req.rd;
			rsp_q.data  <= req.rd ? rd_d : RD_IDLE;
		end
	end

	// Copy of the words toward the converter, so the outputs come from flip-flops.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			cfg_q <= RST_SET;
		end else begin
			cfg_q <= word_w;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	rd_latency_a: assert property (req.rd |=> rsp_q.valid ##1 !rsp_q.valid || $past(req.rd))
		else $error("read answer not one cycle after strobe");

	idle_zero_a: assert property (!rsp_q.valid |-> rsp_q.data == RD_IDLE)
		else $error("read data present without a read");

	id_readback_a: assert property (req.wr && req.addr != ADDR_ECHO && req.addr <= ADDR_LAST
		##1 req.rd && req.addr == $past(req.addr)
		|=> rsp_q.data[TAG_MSB:TAG_LSB] == $past(req.wdata[TAG_MSB:TAG_LSB], 2))
		else $error("tag byte not read back");

	upper_hidden_a: assert property (rsp_q.valid && $past(req.addr) != ADDR_ECHO
		|-> rsp_q.data[SET_MSB:SET_LSB] == 24'h000000)
		else $error("settings leaked on read");

	echo_byte_a: assert property (req.wr && req.addr == ADDR_CFG1
		##1 req.rd && req.addr == ADDR_ECHO
		|=> rsp_q.data[SET_MSB:ECHO_LSB] == $past(req.wdata[SET_MSB:ECHO_LSB], 2))
		else $error("address 5 does not echo word 1 top byte");

	write_store_a: assert property (req.wr && req.addr <= ADDR_LAST
		|=> ##1 cfg_q[$past(req.addr, 2)] == $past(req.wdata, 2))
		else $error("written word not delivered");

	word6_only_a: assert property (req.wr && req.addr == ADDR_CFG6
		|=> ##1 cfg_q[ADDR_CFG0] == $past(cfg_q[ADDR_CFG0]))
		else $error("word 6 write disturbed word 0");

	reset_default_a: assert property (@(posedge clk_sys) $past(sys_rst) && !sys_rst
		|-> cfg_q == RST_SET && !rsp_q.valid)
		else $error("defaults missing after reset");

	unmapped_zero_a: assert property (req.rd && req.addr > ADDR_LAST
		|=> rsp_q.data == RD_IDLE)
		else $error("unmapped address returned data");

	echo_c: cover property (req.wr && req.addr == ADDR_CFG1 ##1 req.rd && req.addr == ADDR_ECHO);
	tag_c: cover property (req.wr && req.addr == ADDR_CFG6 ##[1:4] req.rd && req.addr == ADDR_CFG6);
	b2b_c: cover property (req.rd ##1 req.rd ##1 req.wr);

endmodule : tdc_config_register_bank

// ==== test/cfg_host.sv ====
// Host model for the register port: one-cycle write and read strobes.
// Assumes the bank answers a read in the cycle after the strobe.
`timescale 1ns/1ps
module cfg_host import tdc_cfg_pkg::*; (
	input  wire logic     clk_sys,  // System clock.
	input  wire logic     sys_rst,  // Reset, driven by the bench.
	input  wire reg_rsp_t rsp_q,    // Read answer from the bank.
	output reg_req_t      req       // Requests to the bank.
);
	initial req = '0;
	task automatic write_word(input logic [2:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk_sys);
		req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask : write_word
	task automatic read_word(input logic [2:0] a, output reg_rsp_t r);
		@(posedge clk_sys);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
		@(posedge clk_sys);
		req.rd <= 1'b0;
		@(posedge clk_sys);
		r = rsp_q;
	endtask : read_word
endmodule : cfg_host

// ==== test/tb_tdc_config_register_bank.sv ====
// Self-checking bench for the configuration register bank.
// Drives the register port through the host model on one 50 MHz clock.
`timescale 1ns/1ps
module tb_tdc_config_register_bank import tdc_cfg_pkg::*;;
	logic     clk_sys;
	logic     sys_rst;
	reg_req_t req;
	reg_rsp_t rsp_q;
	cfg_set_t cfg_q;
	cfg_set_t exp_set;
	int       err_total;
	int       num_checks;
	tdc_config_register_bank tdc_config_register_bank_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.req(req), .rsp_q(rsp_q), .cfg_q(cfg_q));
	cfg_host cfg_host_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .rsp_q(rsp_q), .req(req));
	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	function automatic logic [31:0] exp_rd(input logic [2:0] a);
		if (a == ADDR_ECHO) return {exp_set[1][31:24], 16'h0000, exp_set[5][7:0]};
		if (a > ADDR_LAST) return 32'h00000000;
		return {24'h000000, exp_set[a][7:0]};
	endfunction : exp_rd
	task automatic check_all();
		reg_rsp_t r;
		for (int i = 0; i < NUM_WORDS; i++) chk({1'b0, cfg_q[i]}, {1'b0, exp_set[i]});
		for (int a = 0; a < 8; a++) begin
			cfg_host_i.read_word(3'(a), r);
			chk(r, {1'b1, exp_rd(3'(a))});
		end
	endtask : check_all
	task automatic final_report();
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : final_report
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	initial begin
		#100000;
		err_total++;
		final_report();
	end
	initial begin
		logic [23:0] s;
		reg_rsp_t    r;
		sys_rst = 1'b1;
		err_total = 0;
		num_checks = 0;
		exp_set = RST_SET;
		repeat (5) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		check_all();
		// Word 0 keeps its default settings; the others and address 7 get a pattern.
		for (int a = 0; a < 8; a++) begin
			s = (a == 0) ? RST_CFG0[31:8] : 24'h3CA596 + 24'(a);
			cfg_host_i.write_word(3'(a), {s, 8'hE0 | 8'(a)});
			if (a < NUM_WORDS) exp_set[a] = {s, 8'hE0 | 8'(a)};
		end
		cfg_host_i.write_word(ADDR_CFG1, 32'hC5000011);
		exp_set[1] = 32'hC5000011;
		cfg_host_i.read_word(ADDR_ECHO, r);
		chk(r, {1'b1, exp_rd(ADDR_ECHO)});
		repeat (2) @(posedge clk_sys);
		check_all();
		// A second reset in mid-run must bring every word back to its default.
		@(posedge clk_sys);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		exp_set = RST_SET;
		check_all();
		final_report();
	end
endmodule : tb_tdc_config_register_bank
